// *** rtl/floppy_drive_pkg.sv ***
// Constants, layouts and carriers for the drive interface block
package floppy_drive_pkg;
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ERASE_DELAY_NS = 200;
	localparam int ERASE_DELAY_CYC = (ERASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] TRACK_LAST = 8'h4f;
	localparam logic [7:0] TRACK_HOME = 8'h00;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] REG_IRQ_ENABLE = 8'h10;
	// Shared pin option modes
	localparam logic [1:0] SHARED_OFF = 2'h0;
	localparam logic [1:0] SHARED_LOCK_IN = 2'h1;
	localparam logic [1:0] SHARED_CHANGE_OUT = 2'h2;
	// Interrupt bit positions
	localparam int IRQ_STEP = 0;
	localparam int IRQ_WRITE = 1;
	localparam int IRQ_READY = 2;
	localparam int IRQ_INDEX = 3;
	localparam int IRQ_TRACK0 = 4;
	localparam int IRQ_W = 5;
	// Reset values
	localparam logic [9:0] CTRL_RESET = 10'h00f;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;
	// Control register layout, bit 0 at the bottom
	typedef struct packed {
		logic [1:0] unit_num;
		logic [1:0] shared_mode;
		logic lock_select_and_strap;
		logic lock_mode_strap;
		logic hl_host_line_strap;
		logic hl_select_gate_strap;
		logic hl_source_strap;
		logic elec_head_load;
	} ctrl_type;
	// Status register layout
	typedef struct packed {
		logic head_load;
		logic spindle;
		logic change;
		logic lock;
		logic head1;
		logic erase;
		logic write_gate;
		logic ready;
		logic selected;
		logic [7:0] track;
	} status_type;
	// Host cable inputs, all active low
	typedef struct packed {
		logic [3:0] unit_select_n;
		logic motor_on_n;
		logic head_load_n;
		logic direction_n;
		logic step_pulse_n;
		logic write_enable_n;
		logic write_stream_n;
		logic head_side_n;
		logic door_lock_n;
	} host_lines_type;
	// Mechanism sensors, active high
	typedef struct packed {
		logic loaded;
		logic up_to_speed;
		logic protected_disk;
		logic index;
		logic read_raw;
	} mech_in_type;
endpackage

// *** rtl/floppy_drive_interface_control.sv ***
// Drive-side interface control: select gating, stepping, write/erase, status
// Notes on behaviour
// - Ready needs option, loaded disk, speed, select
// - Each step pulse moves one track, except outward at track 00 or inward at the last track
// - Write enable opens writing, closes reading
// - Erase lags write enable by fixed delay
// - Controls and status act only when selected; spindle, ungated head load and direct (not ANDed) door lock act regardless of select
// - Track zero output while on track 00
// - Write protect output while disk protected
// - Spindle runs while motor-on asserted
// - Door line locks door, lights busy lamp
// - Drive sends clock and data on one line
// - Shared pin: latched lock input or change flag
// - Head load source: speed or motor-on
// - Head load optionally gated by select
// - Head load optionally gated by host line
// - Lock direct, ANDed with select, or latched
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_interface_control
	import floppy_drive_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Avalon-MM slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	// Host cable, inputs
	input wire host_lines_type i_host_lines,
	input wire logic i_shared_n,
	// Host cable, status outputs and shared pin
	output logic o_drive_ready_n,
	output logic o_track_zero_n,
	output logic o_write_protect_n,
	output logic o_index_pulse_n,
	output logic o_read_stream_n,
	output logic o_status_oe,
	output logic o_shared_n,
	output logic o_shared_oe,
	// Mechanism
	input wire mech_in_type i_mech,
	output logic o_spindle_on,
	output logic o_head_load,
	output logic o_door_lock,
	output logic o_busy_led,
	output logic o_step,
	output logic o_step_inward,
	output logic o_head1,
	output logic o_write_gate,
	output logic o_erase,
	output logic o_write_data,
	output logic o_read_enable
);
	localparam int SYNC_W = 18;
	localparam int ERASE_LAG = ERASE_DELAY_CYC - 1;
	localparam logic [7:0] ERASE_TOP = 8'(ERASE_DELAY_CYC - 1);

	// Synchroniser stages and agreed levels
	logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q;
	host_lines_type hl;
	mech_in_type mi;
	logic shared_in;
	ctrl_type ctrl_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_ev, irq_clr;
	logic [7:0] track_q;
	logic step_prev_q, sel, step_evt, wr, rdy_cond, rdy_raw_q;
	logic ready_q, change_q, lock_q, erase_q, idx_prev_q;
	logic [7:0] erase_cnt_q;
	logic accept, do_write;
	logic [31:0] wmask;
	status_type stat;

	// Three stages; a bit counts once stages two and three agree
	always_ff @(posedge i_core_clk) begin
		s1_q <= {i_shared_n, i_mech, i_host_lines};
		s2_q <= s1_q;
		s3_q <= s2_q;
		if (i_reset) begin
			filt_q <= {SYNC_W{1'b1}} ^ {1'b0, 5'h1f, 12'h000};
		end else begin
			filt_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
		end
	end
	// Cable levels split into fields here; host lines stay active low, only the shared pin is inverted
	assign hl = filt_q[11:0];
	assign mi = filt_q[16:12];
	assign shared_in = ~filt_q[17];

	// Selection by the assigned unit line
	assign sel = ~hl.unit_select_n[ctrl_q.unit_num];
	// Falling step edge only counts when selected
	assign step_evt = sel & step_prev_q & ~hl.step_pulse_n;
	// Protected media never gets written
	assign wr = sel & ~hl.write_enable_n & ~mi.protected_disk;
	assign rdy_cond = ctrl_q.elec_head_load & mi.loaded & mi.up_to_speed & sel;

	// Avalon handshake: one wait cycle, then a single accept cycle
	assign accept = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
	assign do_write = accept & i_avs_write;
	assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
		{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign irq_clr = (do_write && i_avs_address == REG_IRQ_CLEAR) ?
		(i_avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : IRQ_RESET;

	// Status word assembled from live state
	always_comb begin
		stat.head_load = o_head_load;
		stat.spindle = o_spindle_on;
		stat.change = change_q;
		stat.lock = lock_q;
		stat.head1 = o_head1;
		stat.erase = erase_q;
		stat.write_gate = o_write_gate;
		stat.ready = ready_q;
		stat.selected = o_status_oe;
		stat.track = track_q;
	end

	// Waitrequest high at rest; dropped for the accept cycle
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_avs_waitrequest <= 1'b1;
		end else if (accept) begin
			o_avs_waitrequest <= 1'b1;
		end else if (i_avs_read | i_avs_write) begin
			o_avs_waitrequest <= 1'b0;
		end
	end

	// Read data registered ahead of the accept cycle
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && o_avs_waitrequest) begin
			if (i_avs_address == REG_CTRL) begin
				o_avs_readdata <= 32'(ctrl_q);
			end else if (i_avs_address == REG_STATUS) begin
				o_avs_readdata <= 32'(stat);
			end else if (i_avs_address == REG_IRQ_STATUS) begin
				o_avs_readdata <= 32'(irq_stat_q);
			end else if (i_avs_address == REG_IRQ_ENABLE) begin
				o_avs_readdata <= 32'(irq_en_q);
			end else begin
				// Unmapped and write-only offsets read zero
				o_avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// Control and enable registers, byte-lane masked
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ctrl_q <= CTRL_RESET;
			irq_en_q <= IRQ_RESET;
		end else if (do_write && i_avs_address == REG_CTRL) begin
			ctrl_q <= (ctrl_q & ~wmask[9:0]) | (i_avs_writedata[9:0] & wmask[9:0]);
		end else if (do_write && i_avs_address == REG_IRQ_ENABLE) begin
			irq_en_q <= (irq_en_q & ~wmask[IRQ_W-1:0]) | (i_avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
		end
	end

	// Events for the sticky status bits
	always_comb begin
		irq_ev = IRQ_RESET;
		irq_ev[IRQ_STEP] = step_evt;
		irq_ev[IRQ_WRITE] = wr & ~o_write_gate;
		irq_ev[IRQ_READY] = (mi.loaded & mi.up_to_speed) ^ rdy_raw_q;
		irq_ev[IRQ_INDEX] = mi.index & ~idx_prev_q;
		irq_ev[IRQ_TRACK0] = step_evt & (track_q == 8'h01) & hl.direction_n;
	end

	// Sticky bits; a new event beats a clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			irq_stat_q <= IRQ_RESET;
			o_irq <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			o_irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// Edge memories
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			step_prev_q <= 1'b1;
			idx_prev_q <= 1'b0;
			rdy_raw_q <= 1'b0;
		end else begin
			step_prev_q <= hl.step_pulse_n;
			idx_prev_q <= mi.index;
			rdy_raw_q <= mi.loaded & mi.up_to_speed;
		end
	end

	// Carriage position; clamped so the stepper never overruns the stops
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			track_q <= TRACK_HOME;
			o_step <= 1'b0;
			o_step_inward <= 1'b0;
		end else begin
			o_step <= 1'b0;
			if (step_evt && !hl.direction_n && track_q != TRACK_LAST) begin
				track_q <= track_q + 8'h01;
				o_step <= 1'b1;
				o_step_inward <= 1'b1;
			end else if (step_evt && hl.direction_n && track_q != TRACK_HOME) begin
				track_q <= track_q - 8'h01;
				o_step <= 1'b1;
				o_step_inward <= 1'b0;
			end
		end
	end

	// Status pins, driven only while this unit is selected
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_status_oe <= 1'b0;
			ready_q <= 1'b0;
			o_drive_ready_n <= 1'b1;
			o_track_zero_n <= 1'b1;
			o_write_protect_n <= 1'b1;
			o_index_pulse_n <= 1'b1;
		end else begin
			o_status_oe <= sel;
			ready_q <= rdy_cond;
			o_drive_ready_n <= ~rdy_cond;
			o_track_zero_n <= ~(sel & (track_q == TRACK_HOME));
			o_write_protect_n <= ~(sel & mi.loaded & mi.protected_disk);
			o_index_pulse_n <= ~(sel & mi.index);
		end
	end

	// Serial streams: read blocked while writing
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_read_stream_n <= 1'b1;
			o_read_enable <= 1'b1;
			o_write_gate <= 1'b0;
			o_write_data <= 1'b0;
		end else begin
			o_read_stream_n <= ~(sel & ~wr & mi.read_raw);
			o_read_enable <= ~wr;
			o_write_gate <= wr;
			o_write_data <= wr & ~hl.write_stream_n;
		end
	end

	// Erase trails the write gate on both edges by a fixed count
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			erase_q <= 1'b0;
			erase_cnt_q <= 8'h00;
		end else if (o_write_gate == erase_q) begin
			erase_cnt_q <= 8'h00;
		end else if (erase_cnt_q == ERASE_TOP) begin
			erase_q <= o_write_gate;
			erase_cnt_q <= 8'h00;
		end else begin
			erase_cnt_q <= erase_cnt_q + 8'h01;
		end
	end
	assign o_erase = erase_q;

	// Spindle, head side and head load per strap settings
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_spindle_on <= 1'b0;
			o_head1 <= 1'b0;
			o_head_load <= 1'b0;
		end else begin
			o_spindle_on <= ~hl.motor_on_n;
			if (sel) begin
				o_head1 <= ~hl.head_side_n;
			end
			o_head_load <= (ctrl_q.hl_source_strap ? ~hl.motor_on_n : mi.up_to_speed)
				& (ctrl_q.hl_select_gate_strap ? sel : 1'b1)
				& (ctrl_q.hl_host_line_strap ? ~hl.head_load_n : 1'b1);
		end
	end

	// Door lock; latched mode holds while deselected
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			lock_q <= 1'b0;
		end else if (ctrl_q.lock_mode_strap) begin
			if (sel) begin
				lock_q <= (ctrl_q.shared_mode == SHARED_LOCK_IN) ? shared_in : ~hl.door_lock_n;
			end
		end else begin
			lock_q <= ~hl.door_lock_n & (ctrl_q.lock_select_and_strap ? sel : 1'b1);
		end
	end
	assign o_door_lock = lock_q;
	assign o_busy_led = lock_q;

	// Ready-change flag on the shared pin; a change beats a clear
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			change_q <= 1'b0;
			o_shared_n <= 1'b1;
			o_shared_oe <= 1'b0;
		end else begin
			change_q <= irq_ev[IRQ_READY] | (change_q & ~step_evt);
			o_shared_n <= ~change_q;
			o_shared_oe <= sel & change_q & (ctrl_q.shared_mode == SHARED_CHANGE_OUT);
		end
	end

	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_ready_needs_select: assert property (!o_drive_ready_n |-> $past(sel) && $past(mi.up_to_speed))
		else $error("ready without select or speed");
	a_step_one_track: assert property (step_evt && !hl.direction_n && track_q != TRACK_LAST
		|=> track_q == $past(track_q) + 8'h01 && o_step)
		else $error("inward step did not move one track");
	a_write_blocks_read: assert property (o_write_gate |-> !o_read_enable && o_read_stream_n)
		else $error("read active while writing");
	a_erase_lags_write: assert property ($rose(o_erase) |-> $past(o_write_gate, ERASE_LAG)
		&& $past(o_write_gate))
		else $error("erase rose too early");
	a_status_only_sel: assert property (!o_track_zero_n || !o_index_pulse_n |-> $past(sel))
		else $error("status driven while deselected");
	a_track_zero_flag: assert property (sel && track_q == TRACK_HOME |=> !o_track_zero_n)
		else $error("track zero not shown");
	a_protect_shown: assert property (sel && mi.loaded && mi.protected_disk |=> !o_write_protect_n)
		else $error("write protect not shown");
	a_motor_follows: assert property ($fell(hl.motor_on_n) |=> o_spindle_on)
		else $error("spindle did not start");
	a_lock_held: assert property (ctrl_q.lock_mode_strap && !sel |=> $stable(lock_q))
		else $error("latched lock changed while deselected");
	a_head_side: assert property (sel && !hl.head_side_n |=> o_head1)
		else $error("head 1 not selected");

	a_step_out_track: assert property (step_evt && hl.direction_n && track_q != TRACK_HOME
		|=> track_q == $past(track_q) - 8'h01 && o_step)
		else $error("outward step did not move one track");
	a_write_gated: assert property (o_write_data |-> o_write_gate)
		else $error("write data outside write gate");

	// Head load straps; each term must hold a cycle earlier
	a_head_load_src: assert property (o_head_load |-> $past(ctrl_q.hl_source_strap ? ~hl.motor_on_n : mi.up_to_speed))
		else $error("head load without its source");
	a_head_load_gate: assert property (ctrl_q.hl_select_gate_strap && !sel |=> !o_head_load)
		else $error("head load while deselected");
	a_host_line_gate: assert property (ctrl_q.hl_host_line_strap && hl.head_load_n |=> !o_head_load)
		else $error("head load without host line");
	// Shared pin only driven in change mode while selected
	a_change_pin: assert property (o_shared_oe |-> $past(sel) && $past(ctrl_q.shared_mode) == SHARED_CHANGE_OUT)
		else $error("shared pin driven outside change mode");
	// Interrupt level trails an enabled sticky bit by one cycle
	a_irq_level: assert property (|(irq_stat_q & irq_en_q) |=> o_irq)
		else $error("enabled event gave no interrupt");

	c_head_load: cover property ($rose(o_head_load));
	c_step_taken: cover property (step_evt ##1 o_step);
	c_erase_on: cover property ($rose(o_write_gate) ##[1:40] $rose(o_erase));
	c_ready_seen: cover property ($fell(o_drive_ready_n));
	c_change_out: cover property ($rose(o_shared_oe));
endmodule
`default_nettype wire

// *** tb/host_cable_model.sv ***
// Host controller side of the cable: held levels, step pulses, write stream
`timescale 1ns/1ps
`default_nettype none
module host_cable_model
	import floppy_drive_pkg::*;
(
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Bench commands, active high
	input wire logic [3:0] i_select,
	input wire logic i_motor,
	input wire logic i_dir_in,
	input wire logic i_step_go,
	input wire logic i_write,
	input wire logic i_side,
	input wire logic i_lock,
	input wire logic [7:0] i_wdata,
	// Cable side
	output host_lines_type o_lines,
	output logic o_step_busy
);
	logic [3:0] step_cnt_q; // Low half, then high half of one step
	logic [3:0] slot_q; // Even slot clock, odd slot data
	// Step pulse; each level held six cycles so the drive filter sees it
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			step_cnt_q <= 4'h0;
		end else if (step_cnt_q != 4'h0) begin
			step_cnt_q <= step_cnt_q - 4'h1;
		end else if (i_step_go) begin
			step_cnt_q <= 4'hc;
		end
	end
	// Slot counter of the serial write stream
	always_ff @(posedge i_core_clk) begin
		slot_q <= i_reset ? 4'h0 : slot_q + 4'h1;
	end
	// Levels stay as long as the bench holds them, the model latches nothing
	always_comb begin
		o_lines.unit_select_n = ~i_select;
		o_lines.motor_on_n = !i_motor;
		o_lines.head_load_n = !i_motor;
		o_lines.direction_n = !i_dir_in;
		o_lines.step_pulse_n = !(step_cnt_q > 4'h6);
		o_lines.write_enable_n = !i_write;
		// Clock pulse each even slot, data pulse for a one; idles high
		o_lines.write_stream_n = !(i_write && (!slot_q[0] || i_wdata[slot_q[3:1]]));
		o_lines.head_side_n = !i_side;
		o_lines.door_lock_n = !i_lock;
	end
	assign o_step_busy = step_cnt_q != 4'h0;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench: register bus, cable levels, stepping, write and erase
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import floppy_drive_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq;
	logic irq;
	logic [3:0] sel = 4'h0;
	logic motor = 1'b0, dir_in = 1'b0, step_go = 1'b0, wen = 1'b0, side = 1'b0, lock = 1'b0;
	logic [7:0] wbyte = 8'h00;
	logic step_busy;
	host_lines_type lines;
	mech_in_type mech = '0;
	logic ready_n, tz_n, wp_n, oe, spindle, head1, gate, erase, rd_en, door, hl_out, sh_oe, busy, step_in;
	logic [63:0] exp_q[$]; // Mask over expected read word
	int n_fail = 0;
	int checked = 0;
	int seed = 32'hc76c;
	// Clock, 10 ns period
	always #5 i_core_clk = ~i_core_clk;
	host_cable_model host (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_select(sel), .i_motor(motor),
		.i_dir_in(dir_in), .i_step_go(step_go), .i_write(wen), .i_side(side), .i_lock(lock),
		.i_wdata(wbyte), .o_lines(lines), .o_step_busy(step_busy));
	floppy_drive_interface_control DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
		.i_host_lines(lines), .i_shared_n(1'b1), .o_drive_ready_n(ready_n), .o_track_zero_n(tz_n),
		.o_write_protect_n(wp_n), .o_index_pulse_n(), .o_read_stream_n(), .o_status_oe(oe),
		.o_shared_n(), .o_shared_oe(sh_oe), .i_mech(mech), .o_spindle_on(spindle), .o_head_load(hl_out),
		.o_door_lock(door), .o_busy_led(busy), .o_step(), .o_step_inward(step_in), .o_head1(head1),
		.o_write_gate(gate), .o_erase(erase), .o_write_data(), .o_read_enable(rd_en));
	// One comparison, counted; mismatch reported at once
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge i_core_clk);
		addr <= a;
		rd <= !w;
		wr <= w;
		wdata <= d;
		if (!w) begin
			exp_q.push_back({m, d});
		end
		do @(posedge i_core_clk); while (waitreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Let the cable sync and the output flop settle
	task automatic settle(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// One step through the host model, bounded by a fixed 16-cycle settle
	task automatic step_once(input logic inward);
		dir_in <= inward;
		@(posedge i_core_clk);
		step_go <= 1'b1;
		@(posedge i_core_clk);
		step_go <= 1'b0;
		settle(16);
	endtask
	// Read monitor: oldest note against the accepted read word
	always @(posedge i_core_clk) begin
		if (rd && waitreq === 1'b0) begin
			chk(rdata & exp_q[0][63:32], exp_q[0][31:0], "read word");
			void'(exp_q.pop_front());
		end
	end
	// Random read signal and write byte reach the design
	always @(posedge i_core_clk) begin
		mech.read_raw <= 1'($random(seed));
		wbyte <= 8'($random(seed));
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_fail++;
		end_of_test();
	end
	// Main sequence
	initial begin
		settle(4);
		i_reset <= 1'b0;
		// Control reset value, enable write-back, unmapped and write-only reads
		bus(1'b0, REG_CTRL, {22'h0, CTRL_RESET}, 32'hffffffff);
		bus(1'b1, REG_IRQ_ENABLE, 32'h1f, 32'h0);
		bus(1'b0, REG_IRQ_ENABLE, 32'h1f, 32'h1f);
		bus(1'b0, 8'h20, 32'h0, 32'hffffffff);
		bus(1'b0, REG_IRQ_CLEAR, 32'h0, 32'hffffffff);
		mech.loaded <= 1'b1;
		mech.up_to_speed <= 1'b1;
		settle(8);
		chk(oe, 1'b0, "status oe unselected");
		chk(ready_n, 1'b1, "ready unselected");
		$display("test registers done");
		// Selected unit drives status
		sel <= 4'h1;
		settle(8);
		chk(oe, 1'b1, "status oe selected");
		chk(ready_n, 1'b0, "ready");
		chk(tz_n, 1'b0, "track zero");
		bus(1'b1, REG_IRQ_CLEAR, 32'h1f, 32'h0);
		// Three steps in, three out, one refused at home
		for (int i = 1; i <= 3; i++) begin
			step_once(1'b1);
			bus(1'b0, REG_STATUS, i, 32'hff);
		end
		chk(step_in, 1'b1, "step inward");
		chk(tz_n, 1'b1, "off track zero");
		chk(irq, 1'b1, "step irq");
		bus(1'b1, REG_IRQ_CLEAR, 32'h1f, 32'h0);
		settle(2);
		chk(irq, 1'b0, "irq cleared");
		for (int i = 2; i >= -1; i--) begin
			step_once(1'b0);
			bus(1'b0, REG_STATUS, (i < 0) ? 0 : i, 32'hff);
		end
		chk(tz_n, 1'b0, "back on track zero");
		// Step while unselected is ignored
		sel <= 4'h0;
		step_once(1'b1);
		bus(1'b0, REG_STATUS, 32'h0, 32'hff);
		$display("test stepping done");
		// Write gate, read path, delayed erase
		sel <= 4'h1;
		wen <= 1'b1;
		settle(8);
		chk(gate, 1'b1, "write gate");
		chk(rd_en, 1'b0, "read path off");
		chk(erase, 1'b0, "erase not yet");
		settle(ERASE_DELAY_CYC);
		chk(erase, 1'b1, "erase after delay");
		wen <= 1'b0;
		settle(8);
		chk(rd_en, 1'b1, "read path back");
		$display("test write done");
		// Protect, spindle, head side, door lock
		mech.protected_disk <= 1'b1;
		motor <= 1'b1;
		side <= 1'b1;
		lock <= 1'b1;
		settle(8);
		chk(wp_n, 1'b0, "write protect");
		chk(spindle, 1'b1, "spindle");
		chk(head1, 1'b1, "head one");
		chk(door, 1'b1, "door lock");
		chk(busy, 1'b1, "busy lamp");
		chk(hl_out, 1'b1, "head load");
		$display("test levels done");
		// Ready change flag on the shared pin
		bus(1'b1, REG_CTRL, {22'h0, CTRL_RESET | 10'h080}, 32'h0);
		settle(2);
		chk(sh_oe, 1'b0, "change flag idle");
		mech.up_to_speed <= 1'b0;
		settle(8);
		chk(sh_oe, 1'b1, "change flag driven");
		chk(ready_n, 1'b1, "ready lost");
		$display("test change done");
		settle(4);
		end_of_test();
	end
endmodule
`default_nettype wire
